// file: dv/crc_ref_pkg.sv
// Reference CRC step shared by the bench and the link checker.
// Assumes nothing beyond plain SystemVerilog.
package crc_ref_pkg;
	// One byte in: xor, then eight right shifts
	function automatic logic [15:0] crc_ref(input logic [15:0] c, input logic [7:0] b);
		logic [15:0] r;
		r = c ^ {8'h00, b};
		for (int i = 0; i < 8; i++) r = r[0] ? (r >> 1) ^ 16'hA001 : r >> 1;
		return r;
	endfunction
endpackage

// file: dv/modbus_rtu_slave_framer_props.sv
// Checker on the link between master end and slave end.
// Assumes one clock domain; the bench places it beside the link.
module modbus_rtu_slave_framer_props
	import mb_pkg::*;
	import crc_ref_pkg::*;
#(
	parameter int GAP_CYCLES = 20,
	parameter int DLY_CYC = 20
) (
	input wire logic clk_sys,
	input wire logic arst_n,
	input wire logic cmd_valid,
	input wire logic [7:0] cmd_byte,
	input wire logic rsp_valid,
	input wire logic [7:0] rsp_byte,
	input wire logic rsp_ready
);
	int ic_q; // Idle cycles since last command byte
	int cc_q; // Command bytes in frame
	int rc_q; // Answer bytes taken
	logic [7:0] addr_q; // Last command address
	logic [7:0] fc_q; // Last command function
	logic [15:0] ccrc_q; // Command residue
	logic [15:0] rcrc_q; // Answer residue
	wire fs = cmd_valid && ic_q >= GAP_CYCLES; // Frame start
	wire rx = rsp_valid && rsp_ready; // Answer byte taken
	// Frame tracking both ways
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			ic_q <= 100000;
			cc_q <= 0;
			rc_q <= 0;
			addr_q <= 8'hFF;
			fc_q <= 8'h00;
			ccrc_q <= 16'hFFFF;
			rcrc_q <= 16'hFFFF;
		end else begin
			ic_q <= cmd_valid ? 0 : (ic_q < 100000 ? ic_q + 1 : ic_q);
			if (cmd_valid) begin
				cc_q <= fs ? 1 : cc_q + 1;
				ccrc_q <= crc_ref(fs ? 16'hFFFF : ccrc_q, cmd_byte);
			end
			if (cmd_valid && !fs && cc_q == 1) fc_q <= cmd_byte;
			if (fs) begin
				addr_q <= cmd_byte;
				rc_q <= 0;
				rcrc_q <= 16'hFFFF;
			end else if (rx) begin
				rc_q <= rc_q + 1;
				rcrc_q <= crc_ref(rcrc_q, rsp_byte);
			end
		end
	end
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!arst_n);
	AST_GAP: assert property ($rose(cmd_valid) |-> ic_q >= GAP_CYCLES) else $error("short gap");
	AST_ADDR_RANGE: assert property (fs |-> cmd_byte <= ADDR_MAX) else $error("bad address");
	AST_NO_BCAST_ANSWER: assert property (rsp_valid |-> addr_q != ADDR_BCAST) else $error("bcast answered");
	AST_ANSWER_ADDR: assert property (rx && rc_q == 0 |-> rsp_byte == addr_q) else $error("answer addr");
	AST_ANSWER_FUNC: assert property (rx && rc_q == 1 |-> rsp_byte[6:0] == fc_q[6:0]) else $error("answer func");
	AST_ANSWER_LEN: assert property (rx |-> rc_q < 37) else $error("answer too long");
	AST_CMD_CRC: assert property ($rose(rsp_valid) |-> ccrc_q == 16'h0000) else $error("answered bad crc");
	AST_ANSWER_CRC: assert property (fs && rc_q > 3 |-> rcrc_q == 16'h0000) else $error("answer crc");
	AST_DELAY: assert property ($rose(rsp_valid) |-> ic_q >= GAP_CYCLES + DLY_CYC) else $error("early answer");
	AST_HALF_DUPLEX: assert property (!(cmd_valid && rsp_valid)) else $error("both drive");
	cover property (rx && rc_q == 1 && rsp_byte == FC_READ);
	cover property (fs && cmd_byte == ADDR_BCAST);
	cover property (rx && rc_q == 1 && rsp_byte == FC_WRITE);
endmodule

// file: dv/modbus_rtu_slave_framer_tb.sv
// Bench: master and slave ends on one link, a second slave fed by the bench.
// Assumes the design files and the CRC package compile first.
module modbus_rtu_slave_framer_tb;
	timeunit 1ns;
	timeprecision 1ps;
	import mb_pkg::*;
	import crc_ref_pkg::*;
	localparam int GAP = 20; // Short idle gap
	localparam int MSC = 10; // Short ms tick
	logic clk_sys = 1'b0;
	logic arst_n = 1'b0;
	logic req_valid = 1'b0, req_last = 1'b0, ers = 1'b0;
	logic [7:0] req_byte = 8'h00, resp_byte;
	logic req_ready, resp_valid, resp_done, resp_crc_ok, resp_fail, reg_wr, reg_wr2, crc_err2, disc2, ok2;
	logic [15:0] reg_addr, reg_wdata, reg_addr2, last_addr, last_wdata;
	int fails = 0, cmp_count = 0, cyc = 0, n_wr = 0, n_err2 = 0, n_disc2 = 0, n_rx2 = 0, n_fail = 0;
	int n_ok2 = 0, n_wr2 = 0; // Second slave good frames and writes
	logic [7:0] rq[$]; // Answer bytes seen by the user side
	modbus_link_if link();
	modbus_link_if link2();
	always #25 clk_sys = ~clk_sys;
	initial begin
		link2.cmd_valid = 1'b0;
		link2.cmd_byte = 8'h00;
		link2.rsp_ready = 1'b1;
	end
	mb_master_end #(.GAP_CYCLES(GAP), .MS_CYCLES(MSC), .TMO_MS(10)) mb_master_end_i (.clk_sys(clk_sys),
		.arst_n(arst_n), .link(link.master), .req_valid(req_valid), .req_ready(req_ready), .req_byte(req_byte),
		.req_last(req_last), .enter_requirement_select(ers), .resp_valid(resp_valid), .resp_byte(resp_byte),
		.resp_done(resp_done), .resp_crc_ok(resp_crc_ok), .resp_fail(resp_fail));
	mb_slave_end #(.GAP_CYCLES(GAP), .MS_CYCLES(MSC)) mb_slave_end_i (.clk_sys(clk_sys), .arst_n(arst_n),
		.link(link.slave), .my_addr(8'h01), .response_delay_setting(8'h02), .enter_requirement_select(ers),
		.reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rdata(reg_addr ^ 16'hA5C3),
		.frame_ok(), .crc_err(), .cmd_discard());
	mb_slave_end #(.GAP_CYCLES(GAP), .MS_CYCLES(MSC)) mb_slave_end2_i (.clk_sys(clk_sys), .arst_n(arst_n),
		.link(link2.slave), .my_addr(8'h01), .response_delay_setting(8'h02), .enter_requirement_select(ers),
		.reg_addr(reg_addr2), .reg_wr(reg_wr2), .reg_wdata(), .reg_rdata(reg_addr2), .frame_ok(ok2),
		.crc_err(crc_err2), .cmd_discard(disc2));
	modbus_rtu_slave_framer_props #(.GAP_CYCLES(GAP), .DLY_CYC(2 * MSC)) modbus_rtu_slave_framer_props_i (
		.clk_sys(clk_sys), .arst_n(arst_n), .cmd_valid(link.cmd_valid), .cmd_byte(link.cmd_byte),
		.rsp_valid(link.rsp_valid), .rsp_byte(link.rsp_byte), .rsp_ready(link.rsp_ready));
	// Monitor: answer bytes, pulse counts, hang limit
	always @(posedge clk_sys) begin
		cyc++;
		if (resp_valid === 1'b1) rq.push_back(resp_byte);
		if (reg_wr === 1'b1) begin
			n_wr <= n_wr + 1;
			last_addr <= reg_addr;
			last_wdata <= reg_wdata;
		end
		n_err2 <= n_err2 + (crc_err2 === 1'b1);
		n_disc2 <= n_disc2 + (disc2 === 1'b1);
		n_rx2 <= n_rx2 + (link2.rsp_valid === 1'b1);
		n_fail <= n_fail + (resp_fail === 1'b1);
		n_ok2 <= n_ok2 + (ok2 === 1'b1);
		n_wr2 <= n_wr2 + (reg_wr2 === 1'b1);
		if (cyc == 12000) begin
			fails++;
			conclude();
		end
	end
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			fails++;
			$display("mismatch at %0t: saw %h wanted %h", $time, seen, exp);
		end
	endtask
	// Appends the check field, low byte first
	function automatic void add_crc(ref logic [7:0] q[$]);
		logic [15:0] c;
		c = 16'hFFFF;
		foreach (q[i]) c = crc_ref(c, q[i]);
		q.push_back(c[7:0]);
		q.push_back(c[15:8]);
	endfunction
	// Sends a body through the master, compares the answer
	task automatic xfer(input logic [7:0] b[$], input logic [7:0] e[$]);
		int n;
		rq.delete();
		foreach (b[i]) begin
			req_valid <= 1'b1;
			req_byte <= b[i];
			req_last <= (i == b.size() - 1);
			@(posedge clk_sys);
			while (req_ready !== 1'b1) @(posedge clk_sys);
		end
		req_valid <= 1'b0;
		req_last <= 1'b0;
		n = 0;
		while (resp_done !== 1'b1 && n < 1500) begin
			@(posedge clk_sys);
			n++;
		end
		if (e.size() > 0) check(resp_crc_ok, 1'b1);
		check(resp_done, e.size() > 0);
		check(rq.size(), e.size());
		foreach (e[i]) check(rq[i], e[i]);
	endtask
	// Read of two words, loopback, unknown function
	task automatic t_reads();
		logic [7:0] e[$];
		e = '{8'h01, FC_READ, 8'h04, 8'hA5, 8'hE3, 8'hA5, 8'hE2};
		add_crc(e);
		xfer('{8'h01, FC_READ, 8'h00, 8'h20, 8'h00, 8'h02}, e);
		e = '{8'h01, FC_LOOP, 8'h00, 8'h00, 8'hA5, 8'h37};
		add_crc(e);
		xfer('{8'h01, FC_LOOP, 8'h00, 8'h00, 8'hA5, 8'h37}, e);
		e = '{8'h01, 8'h84, EXC_FUNC};
		add_crc(e);
		xfer('{8'h01, 8'h04, 8'h00, 8'h00, 8'h00, 8'h01}, e);
	endtask
	// Broadcast write is done silently; unicast write answered
	task automatic t_writes();
		logic [7:0] e[$];
		xfer('{8'h02, FC_READ, 8'h00, 8'h20, 8'h00, 8'h01}, e);
		xfer('{8'h00, FC_WRITE, 8'h00, 8'h05, 8'h00, 8'h01, 8'h02, 8'h12, 8'h34}, e);
		check(n_wr, 1);
		check(last_wdata, 16'h1234);
		e = '{8'h01, FC_WRITE, 8'h00, 8'h01, 8'h00, 8'h02};
		add_crc(e);
		xfer('{8'h01, FC_WRITE, 8'h00, 8'h01, 8'h00, 8'h02, 8'h04, 8'h00, 8'h01, 8'h17, 8'h70}, e);
		check(n_wr, 3);
		check(last_addr, 16'h0002);
		check(last_wdata, 16'h1770);
	endtask
	// Drives one frame onto the second link, then idles
	task automatic put2(input logic [7:0] f[$]);
		foreach (f[i]) begin
			link2.cmd_valid <= 1'b1;
			link2.cmd_byte <= f[i];
			@(posedge clk_sys);
		end
		link2.cmd_valid <= 1'b0;
		link2.cmd_byte <= ~f[f.size() - 1];
		repeat (150) @(posedge clk_sys);
	endtask
	// Bad check field, writes inside long guards, read inside guard
	task automatic t_link2();
		logic [7:0] r[$], w[$], v[$];
		r = '{8'h01, FC_READ, 8'h00, 8'h20, 8'h00, 8'h01};
		add_crc(r);
		w = '{8'h01, FC_WRITE, 8'h00, 8'h07, 8'h00, 8'h01, 8'h02, 8'hBE, 8'hEF};
		add_crc(w);
		v = '{8'h01, FC_WRITE, 8'h0F, 8'h00, 8'h00, 8'h01, 8'h02, 8'h00, 8'h01};
		add_crc(v);
		r[7] = ~r[7];
		put2(r);
		check(n_err2, 1);
		check(n_rx2, 0);
		r[7] = ~r[7];
		ers <= 1'b1;
		put2(w);
		repeat (600) @(posedge clk_sys);
		put2(w);
		check(n_disc2, 1);
		check(n_wr2, 1);
		put2(r);
		check(n_rx2, 15);
		check(n_ok2, 3);
		repeat (1200) @(posedge clk_sys);
		ers <= 1'b0;
		put2(v);
		repeat (600) @(posedge clk_sys);
		put2(w);
		check(n_disc2, 2);
		check(n_wr2, 2);
		check(n_rx2, 23);
	endtask
	task automatic conclude();
		$display("comparisons %0d mismatches %0d", cmp_count, fails);
		if (fails == 0 && cmp_count > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	initial begin
		repeat (16) @(posedge clk_sys);
		arst_n <= 1'b1;
		@(posedge clk_sys);
		t_reads();
		t_writes();
		t_link2();
		check(n_fail, 1);
		conclude();
	end
endmodule

// file: logic/mb_master_end.sv
// Master end: request FIFO, frame sender with CRC, answer checker, spacing and retry timers.
// Assumes a user that streams each command body (address to last data byte) with a last flag.

module mb_fifo #(
	parameter int WIDTH = 9,
	parameter int DEPTH = 32
) (
	input wire logic clk_sys,
	input wire logic arst_n,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem_q [DEPTH]; // Storage, not reset
	logic [AW:0] wr_q, wr_d, rd_q, rd_d; // Pointers with wrap bit
	logic push, pop;

	// Full when wrap bits differ and indices match
	assign in_ready = !((wr_q[AW] != rd_q[AW]) && (wr_q[AW-1:0] == rd_q[AW-1:0]));
	assign out_valid = (wr_q != rd_q);
	assign out_data = mem_q[rd_q[AW-1:0]];
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;

	// Pointer advance
	always_comb begin
		wr_d = push ? wr_q + 1'b1 : wr_q;
		rd_d = pop ? rd_q + 1'b1 : rd_q;
	end

	// Pointer registers
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			wr_q <= '0;
			rd_q <= '0;
		end else begin
			wr_q <= wr_d;
			rd_q <= rd_d;
		end
	end

	// Storage write
	always_ff @(posedge clk_sys) begin
		if (push) begin
			mem_q[wr_q[AW-1:0]] <= in_data;
		end
	end
endmodule

module mb_master_end #(
	parameter int GAP_CYCLES = mb_pkg::GAP_CYC,
	parameter int MS_CYCLES = mb_pkg::MS_CYC,
	parameter int TMO_MS = mb_pkg::TIMEOUT_MS,
	parameter int MAX_TRY = mb_pkg::RETRIES,
	parameter int FIFO_DEPTH = 32
) (
	input wire logic clk_sys,
	input wire logic arst_n,
	modbus_link_if.master link,
	input wire logic req_valid,
	output logic req_ready,
	input wire logic [mb_pkg::BYTE_W-1:0] req_byte,
	input wire logic req_last,
	input wire logic enter_requirement_select,
	output logic resp_valid,
	output logic [mb_pkg::BYTE_W-1:0] resp_byte,
	output logic resp_done,
	output logic resp_crc_ok,
	output logic resp_fail
);
	import mb_pkg::*;
	localparam int GW = $clog2(GAP_CYCLES + 1);
	localparam int DW = $clog2(MS_CYCLES);

	mst_state_t st_q, st_d; // Sequencer state
	logic [7:0] buf_q [TX_MAX]; // Command body
	logic [7:0] buf_d [TX_MAX];
	logic [5:0] len_q, len_d; // Body length
	logic [5:0] idx_q, idx_d; // Send position
	logic [15:0] crc_q, crc_d; // Running CRC
	logic [11:0] wait_q, wait_d; // Spacing left in ms
	logic [11:0] tmo_q, tmo_d; // Answer wait in ms
	logic [3:0] try_q, try_d; // Resends so far
	logic got_q, got_d; // Answer byte seen
	logic [GW-1:0] gap_q, gap_d; // Idle cycles
	logic [DW-1:0] div_q, div_d; // Tick divider
	logic rv_q, rv_d, done_q, done_d, ok_q, ok_d, fail_q, fail_d; // Output registers
	logic [7:0] rb_q, rb_d;
	logic ms_tick, f_valid, f_pop, f_last;
	logic [7:0] f_byte;
	logic [11:0] spacing;
	logic [15:0] start_reg;

	// Request bytes queue up while a frame is in flight
	mb_fifo #(.WIDTH(9), .DEPTH(FIFO_DEPTH)) u_fifo (
		.clk_sys(clk_sys),
		.arst_n(arst_n),
		.in_valid(req_valid),
		.in_ready(req_ready),
		.in_data({req_last, req_byte}),
		.out_valid(f_valid),
		.out_ready(f_pop),
		.out_data({f_last, f_byte})
	);

	assign f_pop = (st_q == M_LOAD);
	assign ms_tick = (div_q == DW'(MS_CYCLES - 1));
	assign start_reg = {buf_q[2], buf_q[3]};
	assign link.rsp_ready = (st_q == M_LISTEN);
	assign link.cmd_valid = (st_q == M_SEND);
	assign resp_valid = rv_q;
	assign resp_byte = rb_q;
	assign resp_done = done_q;
	assign resp_crc_ok = ok_q;
	assign resp_fail = fail_q;

	// Spacing before the next command, plus one tick for the partial first tick
	always_comb begin
		if (buf_q[1] != FC_WRITE) begin
			spacing = 12'(WAIT_T1_MS + 1);
		end else if (start_reg == ENTER_REG) begin
			spacing = 12'(WAIT_ENT_MAX_MS + 1);
		end else begin
			spacing = enter_requirement_select ? 12'(WAIT_WR1_MS + 1) : 12'(WAIT_WR0_MS + 1);
		end
	end

	// Body bytes, then check field low byte first
	always_comb begin
		if (idx_q < len_q) begin
			link.cmd_byte = buf_q[idx_q];
		end else if (idx_q == len_q) begin
			link.cmd_byte = crc_q[7:0];
		end else begin
			link.cmd_byte = crc_q[15:8];
		end
	end

	// Next-state logic of the sequencer
	always_comb begin
		st_d = st_q;
		buf_d = buf_q;
		len_d = len_q;
		idx_d = idx_q;
		crc_d = crc_q;
		tmo_d = tmo_q;
		try_d = try_q;
		got_d = got_q;
		gap_d = gap_q;
		rv_d = 1'b0;
		rb_d = rb_q;
		done_d = 1'b0;
		ok_d = ok_q;
		fail_d = 1'b0;
		div_d = ms_tick ? '0 : div_q + 1'b1;
		wait_d = (ms_tick && wait_q != 12'h000) ? wait_q - 1'b1 : wait_q;
		unique case (st_q)
			M_LOAD: begin
				// Take the body; bytes beyond the longest frame are dropped
				if (f_valid) begin
					if (len_q < TX_MAX) begin
						buf_d[len_q] = f_byte;
						len_d = len_q + 1'b1;
					end
					if (f_last) begin
						st_d = M_HOLD;
						try_d = '0;
					end
				end
			end
			M_HOLD: begin
				// Hold off until the spacing of the last command has run out
				if (wait_q == 12'h000) begin
					st_d = M_SEND;
					idx_d = '0;
					crc_d = CRC_INIT;
				end
			end
			M_SEND: begin
				// One byte per cycle; the slave always takes it
				idx_d = idx_q + 1'b1;
				if (idx_q < len_q) begin
					crc_d = crc_step(crc_q, buf_q[idx_q]);
				end
				if (idx_q == len_q + 1'b1) begin
					if (buf_q[0] == ADDR_BCAST) begin
						st_d = M_LOAD;
						len_d = '0;
						wait_d = spacing;
					end else begin
						st_d = M_LISTEN;
						crc_d = CRC_INIT;
						tmo_d = '0;
						got_d = 1'b0;
						gap_d = '0;
						div_d = '0;
					end
				end
			end
			M_LISTEN: begin
				if (link.rsp_valid) begin
					// Pass the byte on, fold it into the check
					rv_d = 1'b1;
					rb_d = link.rsp_byte;
					crc_d = crc_step(crc_q, link.rsp_byte);
					got_d = 1'b1;
					gap_d = '0;
				end else if (got_q) begin
					// Idle gap ends the answer
					if (gap_q == GW'(GAP_CYCLES - 1)) begin
						done_d = 1'b1;
						ok_d = (crc_q == 16'h0000);
						st_d = M_LOAD;
						len_d = '0;
						wait_d = spacing;
					end else begin
						gap_d = gap_q + 1'b1;
					end
				end else if (ms_tick) begin
					// No answer yet: count toward the timeout
					if (tmo_q == 12'(TMO_MS - 1)) begin
						if (try_q < 4'(MAX_TRY)) begin
							try_d = try_q + 1'b1;
							st_d = M_SEND;
							idx_d = '0;
							crc_d = CRC_INIT;
						end else begin
							fail_d = 1'b1;
							st_d = M_LOAD;
							len_d = '0;
						end
					end else begin
						tmo_d = tmo_q + 1'b1;
					end
				end
			end
		endcase
	end

	// Sequencer registers
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			st_q <= M_LOAD;
			len_q <= '0;
			idx_q <= '0;
			crc_q <= CRC_INIT;
			wait_q <= '0;
			tmo_q <= '0;
			try_q <= '0;
			got_q <= 1'b0;
			gap_q <= '0;
			div_q <= '0;
			rv_q <= 1'b0;
			rb_q <= 8'h00;
			done_q <= 1'b0;
			ok_q <= 1'b0;
			fail_q <= 1'b0;
		end else begin
			st_q <= st_d;
			len_q <= len_d;
			idx_q <= idx_d;
			crc_q <= crc_d;
			wait_q <= wait_d;
			tmo_q <= tmo_d;
			try_q <= try_d;
			got_q <= got_d;
			gap_q <= gap_d;
			div_q <= div_d;
			rv_q <= rv_d;
			rb_q <= rb_d;
			done_q <= done_d;
			ok_q <= ok_d;
			fail_q <= fail_d;
		end
	end

	// Body storage, not reset
	always_ff @(posedge clk_sys) begin
		buf_q <= buf_d;
	end
endmodule

// file: logic/mb_pkg.sv
// Shared constants, types and the CRC step for the serial-bus slave framer and its master.
// Assumes one 20 MHz system clock and a byte-wide link between the two ends.
package mb_pkg;
	localparam int CLK_HZ = 20_000_000; // System clock rate
	localparam int BYTE_W = 8; // Link byte width
	localparam int WORD_W = 16; // Register word width
	localparam int TICK_TIME_MS = 1; // Timer tick period
	localparam int MS_CYC = CLK_HZ / 1000 * TICK_TIME_MS; // Cycles per tick
	localparam int GAP_TIME_US = 4011; // 3.5 characters at 9600 bit/s, 11 bits each
	localparam int GAP_CYC = GAP_TIME_US * (CLK_HZ / 1_000_000); // Idle gap in cycles
	localparam logic [7:0] ADDR_BCAST = 8'h00; // Broadcast address
	localparam logic [7:0] ADDR_MAX = 8'h20; // Highest slave address
	localparam logic [7:0] FC_READ = 8'h03; // Read registers
	localparam logic [7:0] FC_LOOP = 8'h08; // Loopback test
	localparam logic [7:0] FC_WRITE = 8'h10; // Write multiple registers
	localparam logic [7:0] FC_EXC = 8'h80; // Exception flag on function code
	localparam logic [7:0] EXC_FUNC = 8'h01; // Unsupported function
	localparam logic [7:0] EXC_VALUE = 8'h03; // Bad quantity or length
	localparam logic [5:0] CMD_LEN = 6'h08; // Read and loopback command length
	localparam logic [5:0] RSP_FIX_LEN = 6'h08; // Loopback and write response length
	localparam logic [5:0] READ_RSP_BASE = 6'h05; // Read response length without data
	localparam logic [5:0] WRITE_BASE = 6'h09; // Write command length without data
	localparam logic [5:0] EXC_LEN = 6'h05; // Exception response length
	localparam logic [5:0] MIN_FRAME = 6'h04; // Shortest frame worth checking
	localparam logic [5:0] RX_MAX = 6'h29; // Longest command, 41 bytes
	localparam logic [5:0] TX_MAX = 6'h27; // Longest command body without check field
	localparam logic [15:0] MAX_QTY = 16'h0010; // Registers per read or write
	localparam logic [15:0] CRC_INIT = 16'hFFFF; // CRC start value
	localparam logic [15:0] CRC_POLY = 16'hA001; // CRC feedback constant
	localparam logic [15:0] ENTER_REG = 16'h0F00; // Register whose write is the save command
	localparam int WAIT_T1_MS = 5; // Control, I/O and read spacing
	localparam int WAIT_WR0_MS = 50; // Write spacing, enter selection 0
	localparam int WAIT_WR1_MS = 200; // Write spacing, enter selection 1
	localparam int WAIT_ENT_MIN_MS = 200; // Shortest save spacing
	localparam int WAIT_ENT_MAX_MS = 2000; // Longest save spacing
	localparam int TIMEOUT_MS = 100; // Master answer timeout
	localparam int RETRIES = 2; // Master resends before giving up

	typedef enum logic [2:0] {S_RX, S_CHECK, S_EXEC, S_DELAY, S_TX} dev_state_t;
	typedef enum logic [1:0] {M_LOAD, M_HOLD, M_SEND, M_LISTEN} mst_state_t;

	// One byte into the CRC: xor in, then eight shift steps
	function automatic logic [15:0] crc_step(input logic [15:0] crc, input logic [7:0] b);
		logic [15:0] c;
		c = crc ^ {8'h00, b};
		for (int i = 0; i < 8; i++) begin
			c = c[0] ? ((c >> 1) ^ CRC_POLY) : (c >> 1);
		end
		return c;
	endfunction
endpackage

// file: logic/mb_slave_end.sv
// Slave end: frame receiver with gap detection, CRC check, command execution, delayed answer.
// Assumes a register port whose read data follows reg_addr in the same cycle.
module mb_slave_end #(
	parameter int GAP_CYCLES = mb_pkg::GAP_CYC,
	parameter int MS_CYCLES = mb_pkg::MS_CYC
) (
	input wire logic clk_sys,
	input wire logic arst_n,
	modbus_link_if.slave link,
	input wire logic [mb_pkg::BYTE_W-1:0] my_addr,
	input wire logic [mb_pkg::BYTE_W-1:0] response_delay_setting,
	input wire logic enter_requirement_select,
	output logic [mb_pkg::WORD_W-1:0] reg_addr,
	output logic reg_wr,
	output logic [mb_pkg::WORD_W-1:0] reg_wdata,
	input wire logic [mb_pkg::WORD_W-1:0] reg_rdata,
	output logic frame_ok,
	output logic crc_err,
	output logic cmd_discard
);
	import mb_pkg::*;
	localparam int GW = $clog2(GAP_CYCLES + 1);
	localparam int DW = $clog2(MS_CYCLES);

	dev_state_t st_q, st_d; // Frame state
	logic [7:0] buf_q [RX_MAX]; // Received frame
	logic [7:0] buf_d [RX_MAX];
	logic [5:0] len_q, len_d; // Bytes stored
	logic ovf_q, ovf_d; // Frame too long
	logic act_q, act_d; // Frame under way
	logic [GW-1:0] gap_q, gap_d; // Idle cycles
	logic [15:0] crc_q, crc_d; // Running CRC, receive then send
	logic [5:0] idx_q, idx_d; // Write or send position
	logic exc_q, exc_d; // Answer is an exception
	logic [7:0] code_q, code_d; // Exception code
	logic bc_q, bc_d; // Frame was broadcast
	logic [10:0] guard_q, guard_d; // Write spacing left in ms
	logic [7:0] dly_q, dly_d; // Answer delay left in ms
	logic [DW-1:0] div_q, div_d; // Tick divider
	logic ok_q, ok_d, cerr_q, cerr_d, disc_q, disc_d; // Event outputs
	logic ms_tick, qty_ok, hits_enter;
	logic [7:0] fc, tx_byte;
	logic [15:0] start, qty;
	logic [5:0] wlen, tx_len, word_k, wofs;
	dev_state_t resp_st;

	assign ms_tick = (div_q == DW'(MS_CYCLES - 1));
	assign fc = buf_q[1];
	assign start = {buf_q[2], buf_q[3]};
	assign qty = {buf_q[4], buf_q[5]};
	assign qty_ok = (qty != 16'h0000) && (qty <= MAX_QTY);
	assign wlen = WRITE_BASE + {qty[4:0], 1'b0};
	assign word_k = 6'(idx_q - 6'h03) >> 1;
	assign wofs = 6'h07 + {idx_q[4:0], 1'b0};
	assign hits_enter = (start <= ENTER_REG) && (({1'b0, start} + {1'b0, qty}) > {1'b0, ENTER_REG});
	// From the stored address, not the next-state value, so no loop through the frame logic
	assign resp_st = (buf_q[0] == ADDR_BCAST) ? S_RX : S_DELAY;
	assign link.rsp_valid = (st_q == S_TX);
	assign link.rsp_byte = tx_byte;
	assign frame_ok = ok_q;
	assign crc_err = cerr_q;
	assign cmd_discard = disc_q;

	// Answer length by kind
	always_comb begin
		if (exc_q) begin
			tx_len = EXC_LEN;
		end else if (fc == FC_READ) begin
			tx_len = READ_RSP_BASE + {qty[4:0], 1'b0};
		end else begin
			tx_len = RSP_FIX_LEN;
		end
	end

	// Answer byte at the send position, check field low byte first
	always_comb begin
		if (idx_q == tx_len - 6'h02) begin
			tx_byte = crc_q[7:0];
		end else if (idx_q == tx_len - 6'h01) begin
			tx_byte = crc_q[15:8];
		end else if (idx_q == 6'h00) begin
			tx_byte = buf_q[0];
		end else if (idx_q == 6'h01) begin
			tx_byte = exc_q ? (fc | FC_EXC) : fc;
		end else if (exc_q) begin
			tx_byte = code_q;
		end else if (fc == FC_READ) begin
			// Byte count, then each word high byte first
			if (idx_q == 6'h02) begin
				tx_byte = {qty[6:0], 1'b0};
			end else begin
				tx_byte = idx_q[0] ? reg_rdata[15:8] : reg_rdata[7:0];
			end
		end else begin
			tx_byte = buf_q[idx_q];
		end
	end

	// Register port: write walk in execute, read walk while sending
	always_comb begin
		reg_wr = (st_q == S_EXEC);
		reg_wdata = {buf_q[wofs], buf_q[wofs + 6'h01]};
		reg_addr = (st_q == S_EXEC) ? start + {10'h000, idx_q} : start + {10'h000, word_k};
	end

	// Next-state logic of the frame handler
	always_comb begin
		st_d = st_q;
		buf_d = buf_q;
		len_d = len_q;
		ovf_d = ovf_q;
		act_d = act_q;
		gap_d = gap_q;
		crc_d = crc_q;
		idx_d = idx_q;
		exc_d = exc_q;
		code_d = code_q;
		bc_d = bc_q;
		dly_d = dly_q;
		ok_d = 1'b0;
		cerr_d = 1'b0;
		disc_d = 1'b0;
		div_d = ms_tick ? '0 : div_q + 1'b1;
		guard_d = (ms_tick && guard_q != 11'h000) ? guard_q - 1'b1 : guard_q;
		unique case (st_q)
			S_RX: begin
				if (link.cmd_valid) begin
					// Store up to RX_MAX bytes, fold every byte, check field included
					if (len_q < RX_MAX) begin
						buf_d[len_q] = link.cmd_byte;
						len_d = len_q + 1'b1;
					end else begin
						ovf_d = 1'b1;
					end
					crc_d = crc_step(crc_q, link.cmd_byte);
					act_d = 1'b1;
					gap_d = '0;
				end else if (act_q) begin
					// Frame ends after the idle gap
					if (gap_q == GW'(GAP_CYCLES - 1)) begin
						st_d = S_CHECK;
					end else begin
						gap_d = gap_q + 1'b1;
					end
				end
			end
			S_CHECK: begin
				// Decide on the frame; the receiver restarts for the next one
				st_d = S_RX;
				len_d = '0;
				ovf_d = 1'b0;
				act_d = 1'b0;
				gap_d = '0;
				crc_d = CRC_INIT;
				idx_d = '0;
				exc_d = 1'b0;
				code_d = EXC_VALUE;
				bc_d = (buf_q[0] == ADDR_BCAST);
				dly_d = response_delay_setting;
				div_d = '0;
				if (ovf_q || len_q < MIN_FRAME) begin
					st_d = S_RX;
				end else if (crc_q != 16'h0000) begin
					cerr_d = 1'b1;
				end else if ((buf_q[0] == my_addr || bc_d) && buf_q[0] <= ADDR_MAX) begin
					ok_d = 1'b1;
					if (fc == FC_WRITE) begin
						if (!qty_ok || buf_q[6] != {qty[6:0], 1'b0} || len_q != wlen) begin
							exc_d = 1'b1;
							st_d = resp_st;
						end else if (guard_q != 11'h000) begin
							disc_d = 1'b1;
						end else begin
							st_d = S_EXEC;
						end
					end else if (fc == FC_READ || fc == FC_LOOP) begin
						// Served even inside a write spacing
						if (len_q == CMD_LEN) begin
							exc_d = (fc == FC_READ) && !qty_ok;
							st_d = resp_st;
						end
					end else begin
						exc_d = 1'b1;
						code_d = EXC_FUNC;
						st_d = resp_st;
					end
				end
			end
			S_EXEC: begin
				// One register per cycle, then arm the write spacing
				idx_d = idx_q + 1'b1;
				if ({10'h000, idx_q} == qty - 16'h0001) begin
					idx_d = '0;
					st_d = bc_q ? S_RX : S_DELAY;
					div_d = '0;
					if (hits_enter) begin
						guard_d = 11'(WAIT_ENT_MIN_MS);
					end else begin
						guard_d = enter_requirement_select ? 11'(WAIT_WR1_MS) : 11'(WAIT_WR0_MS);
					end
				end
			end
			S_DELAY: begin
				// Hold the answer for the configured number of ms
				if (dly_q == 8'h00) begin
					st_d = S_TX;
				end else if (ms_tick) begin
					dly_d = dly_q - 1'b1;
				end
			end
			S_TX: begin
				// Advance only when the master takes the byte
				if (link.rsp_ready) begin
					idx_d = idx_q + 1'b1;
					if (idx_q < tx_len - 6'h02) begin
						crc_d = crc_step(crc_q, tx_byte);
					end
					if (idx_q == tx_len - 6'h01) begin
						st_d = S_RX;
						idx_d = '0;
						crc_d = CRC_INIT;
					end
				end
			end
			default: begin
				st_d = S_RX;
			end
		endcase
	end

	// Frame handler registers
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			st_q <= S_RX;
			len_q <= '0;
			ovf_q <= 1'b0;
			act_q <= 1'b0;
			gap_q <= '0;
			crc_q <= CRC_INIT;
			idx_q <= '0;
			exc_q <= 1'b0;
			code_q <= 8'h00;
			bc_q <= 1'b0;
			guard_q <= '0;
			dly_q <= 8'h00;
			div_q <= '0;
			ok_q <= 1'b0;
			cerr_q <= 1'b0;
			disc_q <= 1'b0;
		end else begin
			st_q <= st_d;
			len_q <= len_d;
			ovf_q <= ovf_d;
			act_q <= act_d;
			gap_q <= gap_d;
			crc_q <= crc_d;
			idx_q <= idx_d;
			exc_q <= exc_d;
			code_q <= code_d;
			bc_q <= bc_d;
			guard_q <= guard_d;
			dly_q <= dly_d;
			div_q <= div_d;
			ok_q <= ok_d;
			cerr_q <= cerr_d;
			disc_q <= disc_d;
		end
	end

	// Frame storage, not reset
	always_ff @(posedge clk_sys) begin
		buf_q <= buf_d;
	end
endmodule

// file: logic/modbus_link_if.sv
// Byte link between the master end and the slave end.
// Assumes both ends run on the same clock; response bytes pass one per handshake, command bytes one per valid cycle.
interface modbus_link_if;
	logic cmd_valid; // Master drives a command byte
	logic [7:0] cmd_byte; // Command byte
	logic rsp_valid; // Slave drives a response byte
	logic [7:0] rsp_byte; // Response byte
	logic rsp_ready; // Master takes the response byte
	modport master (output cmd_valid, output cmd_byte, output rsp_ready, input rsp_valid, input rsp_byte);
	modport slave (input cmd_valid, input cmd_byte, input rsp_ready, output rsp_valid, output rsp_byte);
endinterface
